//--- inc/aidiag_pkg.sv
// Package: record layout, access selectors and timing for the diagnostic record
package aidiag_pkg;
  localparam int unsigned REC_BYTES          = 20;
  localparam int unsigned SHORT_BYTES        = 4;
  localparam logic [7:0]  SET_SHORT          = 8'h00;
  localparam logic [7:0]  SET_FULL           = 8'h01;
  localparam logic [15:0] IDX_SHORT          = 16'h2f00;
  localparam logic [15:0] IDX_FULL           = 16'h2f01;
  localparam logic [15:0] IDX_BYTEWISE       = 16'h5005;
  localparam logic [7:0]  SUB_FIRST          = 8'h02;
  localparam logic [7:0]  SUB_TS_FIRST       = 8'h13;
  // Byte offsets inside the record
  localparam int unsigned OFS_FAULT_SUMMARY  = 0;
  localparam int unsigned OFS_MODULE_CLASS   = 1;
  localparam int unsigned OFS_RSVD_FAULT     = 2;
  localparam int unsigned OFS_INTERNAL_FAULT = 3;
  localparam int unsigned OFS_CHANNEL_KIND   = 4;
  localparam int unsigned OFS_BITS_PER_CHAN  = 5;
  localparam int unsigned OFS_CHANNEL_COUNT  = 6;
  localparam int unsigned OFS_GROUP_FAULTS   = 7;
  localparam int unsigned OFS_CHAN0_FAULT    = 8;
  localparam int unsigned OFS_TIMESTAMP      = 16;
  // Field positions
  localparam int unsigned FS_MODULE_FAIL     = 0;
  localparam int unsigned FS_INTERNAL        = 1;
  localparam int unsigned FS_EXTERNAL        = 2;
  localparam int unsigned FS_CHANNEL         = 3;
  localparam int unsigned FS_AUX_MISSING     = 4;
  localparam int unsigned FS_PARAM           = 7;
  localparam int unsigned IF_BUF_OVERFLOW    = 3;
  localparam int unsigned IF_COMM_ERROR      = 4;
  localparam int unsigned CF_PARAM           = 0;
  localparam int unsigned CF_UNDERFLOW       = 6;
  localparam int unsigned CF_OVERFLOW        = 7;
  // Constant and reset values
  localparam logic [7:0]  MODULE_CLASS_RST   = 8'h15;
  localparam logic [7:0]  CHANNEL_KIND_RST   = 8'h71;
  localparam logic [7:0]  BITS_PER_CHAN_RST  = 8'h08;
  localparam logic [7:0]  CHANNEL_COUNT_RST  = 8'h02;
  localparam logic [7:0]  FAULT_RST          = 8'h00;
  localparam logic [31:0] TIMESTAMP_RST      = 32'h0000_0000;
  // Microsecond tick
  localparam int unsigned CLK_HZ             = 50_000_000;
  localparam int unsigned TICK_US            = 1;
  localparam int unsigned TICK_CYCLES        = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned NUM_CH             = 2;

  typedef struct packed {
    logic module_fail;
    logic internal_err;
    logic external_err;
    logic aux_missing;
    logic param_err;
    logic buf_overflow;
    logic comm_err;
  } module_faults_t;

  typedef struct packed {
    logic param_err;
    logic underflow;
    logic overflow;
  } chan_faults_t;

  typedef struct packed {
    logic        valid;
    logic        by_index;
    logic [15:0] index;
    logic [7:0]  selector;
    logic [4:0]  byte_sel;
  } read_req_t;

  typedef struct packed {
    logic       valid;
    logic       error;
    logic       last;
    logic [7:0] data;
  } read_rsp_t;
endpackage

//--- hw/analog_input_diag_record.sv
// Diagnostic data record of a two-channel analog input module
//
// Overview of operation
// [RULE_01] No diagnostic interrupt output exists at all
// [RULE_02] Error lights channel LED and is recorded
// [RULE_03] Record set 01h full, 00h first four
// [RULE_04] Object index 2F01h full, 2F00h first four
// [RULE_05] Index 5005h gives one byte per subindex
// [RULE_06] Fault summary bits 0-4 and 7
// [RULE_07] Module class byte reads 15h
// [RULE_08] Internal faults: overflow bit 3, comms 4
// [RULE_09] Channel kind reads 71h, analog input
// [RULE_10] Diagnostic bits per channel reads 08h
// [RULE_11] Channel count reads 02h
// [RULE_12] Group fault bits 0 and 1
// [RULE_13] Channel byte: parameter, underflow, overflow bits
// [RULE_14] Microsecond ticker from zero, wraps at 2^32
// [RULE_15] Ticker captured on each diagnostic event
// [RULE_16] Reserved and idle fields read zero
// [RULE_17] Any channel fault sets summary and group
`timescale 1ns/1ps
module analog_input_diag_record
  import aidiag_pkg::*;
(
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  input  wire aidiag_pkg::module_faults_t   mod_faults,
  input  wire aidiag_pkg::chan_faults_t [1:0] chan_faults,
  input  wire aidiag_pkg::read_req_t        rd_req,
  output aidiag_pkg::read_rsp_t             rd_rsp,
  output logic [1:0]                        chan_led,
  output logic                              module_fault_led,
  output logic [31:0]                       ticker_us
);
  import aidiag_pkg::*;

  logic [7:0]  fault_summary_q, fault_summary_d;
  logic [7:0]  internal_faults_q, internal_faults_d;
  logic [7:0]  group_faults_q, group_faults_d;
  logic [7:0]  chan_fault_q [NUM_CH];
  logic [7:0]  chan_fault_d [NUM_CH];
  logic [31:0] timestamp_q;
  logic [31:0] ticker_q;
  logic [5:0]  div_q;
  logic        tick_en;
  logic [7:0]  rec_byte;
  logic        diag_event;
  logic [1:0]  chan_any;
  read_rsp_t   rsp_q;

  // Microsecond enable from the system clock
  assign tick_en = (div_q == 6'(TICK_CYCLES - 1));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_q <= '0;
    end else begin
      div_q <= tick_en ? '0 : div_q + 6'd1;
    end
  end

  // Free running; the natural 32-bit wrap is the documented rollover
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ticker_q <= TIMESTAMP_RST; // [RULE_14]
    end else if (tick_en) begin
      ticker_q <= ticker_q + 32'd1; // [RULE_14]
    end
  end
  assign ticker_us = ticker_q;

  // Per-channel bytes follow the live fault inputs; reserved bits stay zero
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_chan
      always_comb begin
        chan_fault_d[g] = FAULT_RST; // [RULE_16]
        chan_fault_d[g][CF_PARAM]     = chan_faults[g].param_err; // [RULE_13]
        chan_fault_d[g][CF_UNDERFLOW] = chan_faults[g].underflow; // [RULE_13]
        chan_fault_d[g][CF_OVERFLOW]  = chan_faults[g].overflow; // [RULE_13]
      end
      assign chan_any[g] = |chan_fault_d[g]; // [RULE_17]
    end
  endgenerate

  always_comb begin
    fault_summary_d = FAULT_RST;
    fault_summary_d[FS_MODULE_FAIL] = mod_faults.module_fail; // [RULE_06]
    fault_summary_d[FS_INTERNAL]    = mod_faults.internal_err; // [RULE_06]
    fault_summary_d[FS_EXTERNAL]    = mod_faults.external_err; // [RULE_06]
    fault_summary_d[FS_CHANNEL]     = |chan_any; // [RULE_17]
    fault_summary_d[FS_AUX_MISSING] = mod_faults.aux_missing; // [RULE_06]
    fault_summary_d[FS_PARAM]       = mod_faults.param_err; // [RULE_06]
    internal_faults_d = FAULT_RST;
    internal_faults_d[IF_BUF_OVERFLOW] = mod_faults.buf_overflow; // [RULE_08]
    internal_faults_d[IF_COMM_ERROR]   = mod_faults.comm_err; // [RULE_08]
    group_faults_d = {6'h00, chan_any}; // [RULE_12]
  end

  // A diagnostic event is any change of the recorded error state
  assign diag_event = (fault_summary_d != fault_summary_q)
                   || (internal_faults_d != internal_faults_q)
                   || (chan_fault_d[0] != chan_fault_q[0])
                   || (chan_fault_d[1] != chan_fault_q[1]);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fault_summary_q   <= FAULT_RST;
      internal_faults_q <= FAULT_RST;
      group_faults_q    <= FAULT_RST;
      chan_fault_q[0]   <= FAULT_RST;
      chan_fault_q[1]   <= FAULT_RST;
      timestamp_q       <= TIMESTAMP_RST;
    end else begin
      fault_summary_q   <= fault_summary_d; // [RULE_02]
      internal_faults_q <= internal_faults_d;
      group_faults_q    <= group_faults_d;
      chan_fault_q[0]   <= chan_fault_d[0];
      chan_fault_q[1]   <= chan_fault_d[1];
      if (diag_event) begin
        timestamp_q <= ticker_q; // [RULE_15]
      end
    end
  end

  // Errors are only lit and recorded; no interrupt pin exists [RULE_01]
  // LEDs come straight from the recorded bytes so both always agree
  assign chan_led[0]      = |chan_fault_q[0]; // [RULE_02]
  assign chan_led[1]      = |chan_fault_q[1]; // [RULE_02]
  assign module_fault_led = |fault_summary_q;

  // Record image byte lookup
  function automatic logic [7:0] rec_lookup(input logic [4:0] ofs);
    logic [7:0] b;
    b = 8'h00; // [RULE_16]
    unique case (ofs)
      5'(OFS_FAULT_SUMMARY):  b = fault_summary_q;
      5'(OFS_MODULE_CLASS):   b = MODULE_CLASS_RST; // [RULE_07]
      5'(OFS_RSVD_FAULT):     b = FAULT_RST; // [RULE_16]
      5'(OFS_INTERNAL_FAULT): b = internal_faults_q;
      5'(OFS_CHANNEL_KIND):   b = CHANNEL_KIND_RST; // [RULE_09]
      5'(OFS_BITS_PER_CHAN):  b = BITS_PER_CHAN_RST; // [RULE_10]
      5'(OFS_CHANNEL_COUNT):  b = CHANNEL_COUNT_RST; // [RULE_11]
      5'(OFS_GROUP_FAULTS):   b = group_faults_q;
      5'(OFS_CHAN0_FAULT):    b = chan_fault_q[0];
      5'(OFS_CHAN0_FAULT + 1): b = chan_fault_q[1];
      5'(OFS_TIMESTAMP):      b = timestamp_q[7:0];
      5'(OFS_TIMESTAMP + 1):  b = timestamp_q[15:8];
      5'(OFS_TIMESTAMP + 2):  b = timestamp_q[23:16];
      5'(OFS_TIMESTAMP + 3):  b = timestamp_q[31:24];
      default:                b = 8'h00;
    endcase
    return b;
  endfunction

  // Access decode: record set, object index, or byte-per-subindex
  logic       sel_full, sel_short, sel_byte, req_ok, byte_last;
  logic [4:0] eff_ofs, lim_ofs;
  logic [7:0] sub_ofs;
  assign sel_full  = rd_req.by_index ? (rd_req.index == IDX_FULL)
                                     : (rd_req.selector == SET_FULL); // [RULE_03] [RULE_04]
  assign sel_short = rd_req.by_index ? (rd_req.index == IDX_SHORT)
                                     : (rd_req.selector == SET_SHORT); // [RULE_03] [RULE_04]
  assign sel_byte  = rd_req.by_index && (rd_req.index == IDX_BYTEWISE); // [RULE_05]
  // Subindex 12h is skipped: reserved bytes span 0Ch..11h, ticker starts 13h
  assign sub_ofs   = (rd_req.selector >= SUB_TS_FIRST)
                   ? rd_req.selector - SUB_TS_FIRST + 8'(OFS_TIMESTAMP)
                   : rd_req.selector - SUB_FIRST; // [RULE_05]
  assign lim_ofs   = sel_short ? 5'(SHORT_BYTES - 1) : 5'(REC_BYTES - 1);
  assign eff_ofs   = sel_byte ? sub_ofs[4:0] : rd_req.byte_sel;
  assign req_ok    = sel_byte ? (rd_req.selector >= SUB_FIRST
                                 && rd_req.selector <= SUB_TS_FIRST + 8'd3
                                 && rd_req.selector != SUB_TS_FIRST - 8'd1)
                              : ((sel_full || sel_short) && rd_req.byte_sel <= lim_ofs);
  assign byte_last = sel_byte || (rd_req.byte_sel == lim_ofs);
  assign rec_byte  = rec_lookup(eff_ofs);

  // Read-only record: answers one cycle after the request, no side effects
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rsp_q <= '0;
    end else begin
      rsp_q.valid <= rd_req.valid;
      rsp_q.error <= rd_req.valid && !req_ok;
      rsp_q.last  <= rd_req.valid && req_ok && byte_last;
      rsp_q.data  <= (rd_req.valid && req_ok) ? rec_byte : 8'h00;
    end
  end
  assign rd_rsp = rsp_q;

  ticker_wraps_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_14]
    tick_en && ticker_q == 32'hffff_ffff |=> ticker_q == 32'h0)
    else $error("ticker did not wrap to zero");
  ticker_step_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_14]
    tick_en |=> ticker_q == $past(ticker_q) + 32'd1 ##1 !tick_en [*8])
    else $error("ticker step or tick spacing wrong");
  stamp_capture_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_15]
    diag_event |=> timestamp_q == $past(ticker_q))
    else $error("timestamp not captured on event");
  led_follows_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_02]
    chan_faults[0] != '0 |=> chan_led[0] && fault_summary_q[FS_CHANNEL])
    else $error("channel error not shown");
  group_bits_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_12]
    group_faults_q[1:0] == {chan_led[1], chan_led[0]} && group_faults_q[7:2] == 6'h00)
    else $error("group fault byte mismatch");
  summary_bits_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_06]
    mod_faults.param_err |=> fault_summary_q[FS_PARAM] && fault_summary_q[6:5] == 2'b00)
    else $error("summary byte wrong");
  internal_bits_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_08]
    mod_faults.comm_err |=> internal_faults_q[IF_COMM_ERROR] && internal_faults_q[2:0] == 3'h0)
    else $error("internal fault byte wrong");
  short_limit_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_03]
    rd_req.valid && !rd_req.by_index && rd_req.selector == SET_SHORT
      && rd_req.byte_sel == 5'd4 |=> rd_rsp.error)
    else $error("short record set not limited");
  class_byte_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_07]
    rd_req.valid && rd_req.by_index && rd_req.index == IDX_BYTEWISE
      && rd_req.selector == 8'h03 |=> rd_rsp.data == 8'h15 && !rd_rsp.error)
    else $error("module class byte wrong");
  kind_byte_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_09]
    rd_req.valid && rd_req.by_index && rd_req.index == IDX_FULL
      && rd_req.byte_sel == 5'd4 |=> rd_rsp.data == 8'h71)
    else $error("channel kind byte wrong");
  // Access checks against the fixed record layout
  full_last_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_03]
    rd_req.valid && !rd_req.by_index && rd_req.selector == 8'h01 && rd_req.byte_sel == 5'd19 |=> rd_rsp.last && !rd_rsp.error)
    else $error("full record last byte wrong");
  full_limit_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_03]
    rd_req.valid && !rd_req.by_index && rd_req.selector == 8'h01 && rd_req.byte_sel == 5'd20 |=> rd_rsp.error && rd_rsp.data == 8'h00)
    else $error("full record not limited");
  short_last_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_03]
    rd_req.valid && !rd_req.by_index && rd_req.selector == 8'h00 && rd_req.byte_sel == 5'd3 |=> rd_rsp.last && !rd_rsp.error)
    else $error("short record last byte wrong");
  short_data_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_03]
    rd_req.valid && !rd_req.by_index && rd_req.selector == 8'h00 && rd_req.byte_sel == 5'd1 |=> rd_rsp.data == 8'h15 && !rd_rsp.error)
    else $error("short record data wrong");
  set_bad_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_03]
    rd_req.valid && !rd_req.by_index && rd_req.selector > 8'h01 |=> rd_rsp.error)
    else $error("unknown record set accepted");
  index_short_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_04]
    rd_req.valid && rd_req.by_index && rd_req.index == 16'h2f00 && rd_req.byte_sel == 5'd4 |=> rd_rsp.error)
    else $error("short index not limited");
  index_last_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_04]
    rd_req.valid && rd_req.by_index && rd_req.index == 16'h2f01 && rd_req.byte_sel == 5'd19 |=> rd_rsp.last && !rd_rsp.error)
    else $error("full index last byte wrong");
  index_bad_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_04]
    rd_req.valid && rd_req.by_index && rd_req.index != 16'h2f00 && rd_req.index != 16'h2f01 && rd_req.index != 16'h5005 |=> rd_rsp.error && !rd_rsp.last)
    else $error("unknown index accepted");
  sub_gap_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_05]
    rd_req.valid && rd_req.by_index && rd_req.index == 16'h5005 && rd_req.selector == 8'h12 |=> rd_rsp.error)
    else $error("subindex gap accepted");
  sub_low_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_05]
    rd_req.valid && rd_req.by_index && rd_req.index == 16'h5005 && rd_req.selector < 8'h02 |=> rd_rsp.error)
    else $error("low subindex accepted");
  sub_high_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_05]
    rd_req.valid && rd_req.by_index && rd_req.index == 16'h5005 && rd_req.selector > 8'h16 |=> rd_rsp.error)
    else $error("high subindex accepted");
  sub_last_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_05]
    rd_req.valid && rd_req.by_index && rd_req.index == 16'h5005 && rd_req.selector >= 8'h02 && rd_req.selector <= 8'h11 |=> rd_rsp.last && !rd_rsp.error)
    else $error("subindex byte not single");
  sub_rsvd_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_16]
    rd_req.valid && rd_req.by_index && rd_req.index == 16'h5005 && rd_req.selector >= 8'h0c && rd_req.selector <= 8'h11 |=> rd_rsp.data == 8'h00)
    else $error("reserved channel byte not zero");
  rsvd_fault_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_16]
    rd_req.valid && rd_req.by_index && rd_req.index == 16'h5005 && rd_req.selector == 8'h04 |=> rd_rsp.data == 8'h00)
    else $error("reserved fault byte not zero");
  sub_kind_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_09]
    rd_req.valid && rd_req.by_index && rd_req.index == 16'h5005 && rd_req.selector == 8'h06 |=> rd_rsp.data == 8'h71)
    else $error("channel kind subindex wrong");
  sub_bits_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_10]
    rd_req.valid && rd_req.by_index && rd_req.index == 16'h5005 && rd_req.selector == 8'h07 |=> rd_rsp.data == 8'h08)
    else $error("bits per channel wrong");
  sub_count_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_11]
    rd_req.valid && rd_req.by_index && rd_req.index == 16'h5005 && rd_req.selector == 8'h08 |=> rd_rsp.data == 8'h02)
    else $error("channel count wrong");
  sub_stamp_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_05]
    rd_req.valid && rd_req.by_index && rd_req.index == 16'h5005 && rd_req.selector == 8'h13 |=> rd_rsp.data == $past(timestamp_q[7:0]))
    else $error("timestamp low byte wrong");
  stamp_top_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_05]
    rd_req.valid && rd_req.by_index && rd_req.index == 16'h5005 && rd_req.selector == 8'h16 |=> rd_rsp.data == $past(timestamp_q[31:24]))
    else $error("timestamp top byte wrong");
  rsp_answer_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_03]
    rd_req.valid |=> rd_rsp.valid)
    else $error("request not answered");
  rsp_pulse_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_03]
    !rd_req.valid |=> !rd_rsp.valid)
    else $error("answer without request");
  error_data_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_16]
    rd_rsp.error |-> rd_rsp.data == 8'h00 && !rd_rsp.last)
    else $error("refused read carries data");
  idle_zero_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_16]
    !rd_rsp.valid |-> rd_rsp.data == 8'h00 && !rd_rsp.error && !rd_rsp.last)
    else $error("idle response not zero");
  // Fault byte, LED, timestamp and ticker checks
  chan1_led_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_02]
    chan_faults[1] != '0 |=> chan_led[1])
    else $error("channel one led not lit");
  led_clear_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_02]
    chan_faults[0] == '0 |=> !chan_led[0])
    else $error("channel zero led stuck");
  module_led_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_02]
    module_fault_led == (fault_summary_q != 8'h00))
    else $error("module led mismatch");
  chan_rsvd_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_13]
    chan_fault_q[0][5:1] == 5'h00 && chan_fault_q[1][5:1] == 5'h00)
    else $error("channel reserved bits set");
  chan_over_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_13]
    chan_faults[0].overflow |=> chan_fault_q[0][7])
    else $error("overflow bit missing");
  chan_under_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_13]
    chan_faults[1].underflow |=> chan_fault_q[1][6])
    else $error("underflow bit missing");
  chan_param_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_13]
    chan_faults[0].param_err |=> chan_fault_q[0][0])
    else $error("channel parameter bit missing");
  summary_chan_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_17]
    fault_summary_q[3] == (|group_faults_q))
    else $error("channel summary bit mismatch");
  summary_fail_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_06]
    mod_faults.module_fail |=> fault_summary_q[0])
    else $error("module failure bit missing");
  internal_bit_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_06]
    mod_faults.internal_err |=> fault_summary_q[1])
    else $error("internal error bit missing");
  external_bit_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_06]
    mod_faults.external_err |=> fault_summary_q[2])
    else $error("external error bit missing");
  aux_bit_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_06]
    mod_faults.aux_missing |=> fault_summary_q[4])
    else $error("aux supply bit missing");
  internal_rsvd_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_08]
    internal_faults_q[7:5] == 3'h0)
    else $error("internal reserved bits set");
  overflow_bit_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_08]
    mod_faults.buf_overflow |=> internal_faults_q[3])
    else $error("buffer overflow bit missing");
  clear_idle_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_16]
    mod_faults == '0 && chan_faults == '0 |=> fault_summary_q == 8'h00 && internal_faults_q == 8'h00)
    else $error("fault bytes not clear");
  stamp_hold_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_15]
    !diag_event |=> $stable(timestamp_q))
    else $error("timestamp moved without event");
  ticker_hold_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_14]
    !tick_en |=> $stable(ticker_q))
    else $error("ticker moved between ticks");
  divider_range_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_14]
    div_q <= 6'd49)
    else $error("tick divider out of range");
endmodule

//--- tb/coupler_model.sv
// Bus coupler model that reads the diagnostic record
`timescale 1ns/1ps
module coupler_model (
  input  wire logic                  clk_sys,
  output aidiag_pkg::read_req_t      rd_req,
  input  wire aidiag_pkg::read_rsp_t rd_rsp
);
  import aidiag_pkg::*;
  initial rd_req = '0;
  // One-cycle strobe, then a bounded wait for the answer
  task automatic read(input logic bx, input logic [15:0] ix, input logic [7:0] sel,
                      input logic [4:0] bs, output read_rsp_t rsp);
    read_req_t req;
    req = '{valid: 1'b1, by_index: bx, index: ix, selector: sel, byte_sel: bs};
    rsp = '0;
    @(negedge clk_sys);
    rd_req = req;
    @(posedge clk_sys);
    for (int k = 0; k < 3 && rsp.valid !== 1'b1; k++) begin
      @(negedge clk_sys);
      if (k == 0) begin
        // Released fields must not keep showing the old request
        rd_req = '{valid: 1'b0, by_index: ~bx, index: ~ix, selector: ~sel, byte_sel: ~bs};
      end
      if (rd_rsp.valid === 1'b1) rsp = rd_rsp;
    end
  endtask
endmodule

//--- tb/tb.sv
// Self-checking bench for the diagnostic record
`timescale 1ns/1ps
module tb;
  import aidiag_pkg::*;
  logic               clk_sys;
  logic               rst;
  module_faults_t     mf;
  chan_faults_t [1:0] cf;
  read_req_t          rd_req;
  read_rsp_t          rd_rsp;
  logic [1:0]         chan_led;
  logic               module_fault_led;
  logic [31:0]        ticker_us, exp_ts, t0;
  logic [15:0]        lfsr = 16'h005f;
  int                 bad_count = 0;
  int                 checked = 0;

  analog_input_diag_record uut (.clk_sys(clk_sys), .rst(rst), .mod_faults(mf),
    .chan_faults(cf), .rd_req(rd_req), .rd_rsp(rd_rsp), .chan_led(chan_led),
    .module_fault_led(module_fault_led), .ticker_us(ticker_us));
  coupler_model rdr (.clk_sys(clk_sys), .rd_req(rd_req), .rd_rsp(rd_rsp));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic any_f(input chan_faults_t c);
    return c.param_err | c.underflow | c.overflow;
  endfunction
  function automatic logic [7:0] rec_byte(input int i);
    case (i)
      0: return {mf.param_err, 2'b00, mf.aux_missing, any_f(cf[0]) | any_f(cf[1]),
                 mf.external_err, mf.internal_err, mf.module_fail};
      1: return 8'h15;
      3: return {3'b000, mf.comm_err, mf.buf_overflow, 3'b000};
      4: return 8'h71;
      5: return 8'h08;
      6: return 8'h02;
      7: return {6'h00, any_f(cf[1]), any_f(cf[0])};
      8, 9: return {cf[i-8].overflow, cf[i-8].underflow, 5'h00, cf[i-8].param_err};
      16, 17, 18, 19: return exp_ts[8*(i-16) +: 8];
      default: return 8'h00;
    endcase
  endfunction

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Last flag is left open on a refused read
  task automatic access(input logic bx, input logic [15:0] ix, input logic [7:0] sel,
                        input logic [4:0] bs, input logic err, input logic lst, input int i);
    read_rsp_t r;
    rdr.read(bx, ix, sel, bs, r);
    check(32'({r.valid, r.error, r.last & !err, r.data}),
          32'({1'b1, err, lst & !err, err ? 8'h00 : rec_byte(i)}));
  endtask
  task automatic sweep();
    for (int n = 0; n <= 20; n++) begin
      access(1'b0, 16'h0000, 8'h01, 5'(n), n == 20, n == 19, n);
      access(1'b1, 16'h2f01, 8'h00, 5'(n), n == 20, n == 19, n);
      if (n <= 4) access(1'b0, 16'h0000, 8'h00, 5'(n), n == 4, n == 3, n);
      if (n <= 4) access(1'b1, 16'h2f00, 8'h00, 5'(n), n == 4, n == 3, n);
    end
    for (int s = 1; s <= 8'h17; s++)
      access(1'b1, 16'h5005, 8'(s), 5'(s), s < 2 || s == 8'h12 || s == 8'h17, 1'b1,
             s < 8'h12 ? s - 2 : s - 3);
    access(1'b0, 16'h0000, 8'h02, 5'h00, 1'b1, 1'b0, 0);
    access(1'b1, 16'h2f02, 8'h00, 5'h00, 1'b1, 1'b0, 0);
  endtask
  // Change faults just after a tick so the captured time is unambiguous
  task automatic apply(input module_faults_t m, input chan_faults_t [1:0] c);
    t0 = ticker_us;
    for (int k = 0; k < 60 && ticker_us === t0; k++) @(negedge clk_sys);
    if ({m, c} !== {mf, cf}) exp_ts = ticker_us;
    mf = m;
    cf = c;
    repeat (2) @(negedge clk_sys);
    check(32'(chan_led), 32'({any_f(c[1]), any_f(c[0])}));
    check(32'(module_fault_led), 32'(rec_byte(0) != 8'h00));
    sweep();
  endtask

  task automatic tally_and_finish();
    if (bad_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    rst = 1'b1;
    mf = '0;
    cf = '0;
    exp_ts = '0;
    repeat (16) @(negedge clk_sys);
    check(ticker_us, 32'h0);
    check(32'(rd_rsp), 32'h0);
    rst = 1'b0;
    @(negedge clk_sys);
    check(ticker_us, 32'h0);
    sweep();
    t0 = ticker_us;
    for (int k = 0; k < 60 && ticker_us === t0; k++) @(negedge clk_sys);
    t0 = ticker_us;
    repeat (50) @(negedge clk_sys);
    check(ticker_us, t0 + 32'h1);
    apply('1, '1);
    repeat (6) begin
      repeat (13) lfsr = lfsr_next(lfsr);
      apply(lfsr[6:0], lfsr[12:7]);
    end
    apply('0, '0);
    tally_and_finish();
  end
endmodule
